//--- hw/pic_cfg.svh
/*
  Constants of the prioritized interrupt controller: level numbers, vectors,
  opcodes, control codes, timing counts.
  Assumes a 125 MHz core clock and an instruction-cycle enable from the core.
*/
`ifndef PIC_CFG_SVH
`define PIC_CFG_SVH

`define PIC_LEVELS 8
`define PIC_LVL_SOFT0 3'h0
`define PIC_LVL_KEY 3'h1
`define PIC_LVL_PADLO 3'h2
`define PIC_LVL_TMR1 3'h3
`define PIC_LVL_TMR0 3'h4
`define PIC_LVL_PSSLOW 3'h5
`define PIC_LVL_PSFAST 3'h6
`define PIC_LVL_PADHI 3'h7

`define PIC_VEC0 12'h040
`define PIC_VEC1 12'h080
`define PIC_VEC2 12'h0C0
`define PIC_VEC3 12'h100
`define PIC_VEC4 12'h140
`define PIC_VEC5 12'h180
`define PIC_VEC6 12'h1C0
`define PIC_VEC7 12'h1E0

`define PIC_OPC0 8'hC8
`define PIC_OPC1 8'hD0
`define PIC_OPC2 8'hD8
`define PIC_OPC3 8'hE0
`define PIC_OPC4 8'hE8
`define PIC_OPC5 8'hF0
`define PIC_OPC6 8'hF8
`define PIC_OPC7 8'hFC

`define PIC_CTRL_RESET 4'hF
`define PIC_CTRL_HI_EN 3
`define PIC_CTRL_LO_EN 2
`define PIC_CTRL_HI_NEG 1
`define PIC_CTRL_LO_NEG 0

`define PIC_LAT_MIN 3
`define PIC_LAT_MAX 5

`endif

//--- hw/pic_pkg.sv
/*
  Types of the prioritized interrupt controller.
  Assumes pic_cfg.svh is included by the design files.
*/
`default_nettype none
package pic_pkg;
  typedef logic [2:0] pic_level_t;
  typedef enum logic [2:0] {
    PIC_RUN = 3'h1,
    PIC_ACK = 3'h2,
    PIC_SLEEP = 3'h4
  } pic_state_e;
endpackage
`default_nettype wire

//--- hw/pic_vector_rom.sv
/*
  Vector and opcode table of the eight levels, registered read data.
  Assumes a level index stable one clock before the data are used.
*/
`include "pic_cfg.svh"
`default_nettype none
module pic_vector_rom
  import pic_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire pic_level_t level,
  output logic [11:0] vector,
  output logic [7:0] opcode
);
  logic [11:0] vectorNext;
  logic [7:0] opcodeNext;
  logic [11:0] vector_reg;
  logic [7:0] opcode_reg;

  always_comb
  begin
    unique case (level)
      3'h0:
      begin
        vectorNext = `PIC_VEC0;
        opcodeNext = `PIC_OPC0;
      end
      3'h1:
      begin
        vectorNext = `PIC_VEC1;
        opcodeNext = `PIC_OPC1;
      end
      3'h2:
      begin
        vectorNext = `PIC_VEC2;
        opcodeNext = `PIC_OPC2;
      end
      3'h3:
      begin
        vectorNext = `PIC_VEC3;
        opcodeNext = `PIC_OPC3;
      end
      3'h4:
      begin
        vectorNext = `PIC_VEC4;
        opcodeNext = `PIC_OPC4;
      end
      3'h5:
      begin
        vectorNext = `PIC_VEC5;
        opcodeNext = `PIC_OPC5;
      end
      3'h6:
      begin
        vectorNext = `PIC_VEC6;
        opcodeNext = `PIC_OPC6;
      end
      3'h7:
      begin
        vectorNext = `PIC_VEC7;
        opcodeNext = `PIC_OPC7;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      vector_reg <= 12'h000;
      opcode_reg <= 8'h00;
    end
    else
    begin
      vector_reg <= vectorNext;
      opcode_reg <= opcodeNext;
    end
  end

  assign vector = vector_reg;
  assign opcode = opcode_reg;
endmodule
`default_nettype wire

//--- hw/pic_controller.sv
/*
  Prioritized interrupt controller: edge detection, pending and active
  registers, priority decode, acknowledge and sleep sequencing.
  Assumes the core gives a one-cycle instrDone pulse per instruction end,
  and one-cycle pulses for enable, disable, return and port accesses.
*/
// Implementation choices: the plain strobed port.
`include "pic_cfg.svh"
`default_nettype none
module pic_controller
  import pic_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic instrDone,
  input wire logic irqEnableInstr,
  input wire logic irqDisableInstr,
  input wire logic returnFromIrqInstr,
  input wire logic sleepInstr,
  input wire logic extPadHigh,
  input wire logic extPadLow,
  input wire logic prescalerFastIrq,
  input wire logic prescalerSlowIrq,
  input wire logic timer0Irq,
  input wire logic timer1Irq,
  input wire logic [3:0] keyLines,
  input wire logic keyPullDown,
  input wire logic keyAtLevel4,
  input wire logic keyPortWrite,
  input wire logic keyPortRead,
  input wire logic [7:0] softTrigger,
  input wire logic ctrlWrite,
  input wire logic [3:0] ctrlData,
  output logic irqRequest,
  output logic ackCycle,
  output logic pushPc,
  output logic [11:0] vectorAddr,
  output logic [7:0] irqOpcode,
  output logic irqEnableFlag,
  output logic sleeping,
  output logic oscRestart,
  output logic [7:0] pendingBits,
  output logic [7:0] activeBits
);
  pic_state_e state_reg, state_next;
  logic [7:0] pending_reg, pending_next;
  logic [7:0] active_reg, active_next;
  logic ien_reg, ien_next;
  logic keyArmed_reg, keyArmed_next;
  logic [3:0] ctrl_reg, ctrl_next;
  logic [3:0] keyPrev_reg;
  logic padHiPrev_reg, padLoPrev_reg;
  logic [7:0] hwReq;
  logic [7:0] req;
  logic keyEdge, padHiEdge, padLoEdge;
  logic [2:0] topPend;
  logic [2:0] topActive;
  logic anyActive;
  logic anyPending;
  logic higher;
  logic [2:0] selLevel_reg, selLevel_next;
  logic [7:0] clearMask;
  logic [11:0] romVector;
  logic [7:0] romOpcode;

  // Edge detection on key port and pads
  always_comb
  begin
    keyEdge = 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      if (keyPullDown)
        keyEdge = keyEdge | (keyLines[i] & ~keyPrev_reg[i]);
      else
        keyEdge = keyEdge | (~keyLines[i] & keyPrev_reg[i]);
    end
    keyEdge = keyEdge & keyArmed_reg;
    padHiEdge = ctrl_reg[`PIC_CTRL_HI_EN] &
      (ctrl_reg[`PIC_CTRL_HI_NEG] ? (padHiPrev_reg & ~extPadHigh)
                                  : (~padHiPrev_reg & extPadHigh));
    padLoEdge = ctrl_reg[`PIC_CTRL_LO_EN] &
      (ctrl_reg[`PIC_CTRL_LO_NEG] ? (padLoPrev_reg & ~extPadLow)
                                  : (~padLoPrev_reg & extPadLow));
  end

  // Request vector per level
  always_comb
  begin
    hwReq = 8'h00;
    hwReq[`PIC_LVL_PADHI] = padHiEdge;
    hwReq[`PIC_LVL_PSFAST] = prescalerFastIrq;
    hwReq[`PIC_LVL_PSSLOW] = prescalerSlowIrq;
    hwReq[`PIC_LVL_TMR0] = timer0Irq | (keyEdge & keyAtLevel4);
    hwReq[`PIC_LVL_TMR1] = timer1Irq;
    hwReq[`PIC_LVL_PADLO] = padLoEdge;
    hwReq[`PIC_LVL_KEY] = keyEdge & ~keyAtLevel4;
    req = hwReq | softTrigger;
  end

  // Priority decode of pending and active
  always_comb
  begin
    topPend = 3'h0;
    topActive = 3'h0;
    for (int i = 0; i < `PIC_LEVELS; i++)
    begin
      if (pending_reg[i] && !active_reg[i])
        topPend = 3'(i);
      if (active_reg[i])
        topActive = 3'(i);
    end
    anyActive = |active_reg;
    anyPending = |(pending_reg & ~active_reg);
    higher = anyPending && (!anyActive || topPend > topActive);
  end

  // Sequencer, pending, active, enable and port state
  always_comb
  begin
    state_next = state_reg;
    ien_next = ien_reg;
    active_next = active_reg;
    selLevel_next = selLevel_reg;
    clearMask = 8'h00;
    keyArmed_next = keyArmed_reg;
    ctrl_next = ctrl_reg;
    if (keyPortWrite)
      keyArmed_next = 1'b1;
    else if (keyPortRead)
      keyArmed_next = 1'b0;
    if (ctrlWrite)
      ctrl_next = ctrlData;
    if (irqEnableInstr)
      ien_next = 1'b1;
    if (irqDisableInstr)
      ien_next = 1'b0;
    unique case (state_reg)
      PIC_RUN:
      begin
        if (returnFromIrqInstr && anyActive)
        begin
          clearMask[topActive] = 1'b1;
          active_next[topActive] = 1'b0;
          ien_next = 1'b1;
          if (active_reg == clearMask && !higher)
            state_next = PIC_SLEEP;
        end
        else if (sleepInstr)
        begin
          ien_next = 1'b1;
          state_next = PIC_SLEEP;
        end
        else if (instrDone && ien_reg && higher)
        begin
          selLevel_next = topPend;
          state_next = PIC_ACK;
        end
      end
      PIC_ACK:
      begin
        active_next[selLevel_reg] = 1'b1;
        state_next = PIC_RUN;
      end
      PIC_SLEEP:
      begin
        if (|pending_reg)
          state_next = PIC_RUN;
      end
    endcase
    pending_next = (pending_reg & ~clearMask) | req;
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      state_reg <= PIC_RUN;
      pending_reg <= 8'h00;
      active_reg <= 8'h00;
      ien_reg <= 1'b0;
      selLevel_reg <= 3'h0;
      keyArmed_reg <= 1'b0;
      ctrl_reg <= `PIC_CTRL_RESET;
      keyPrev_reg <= 4'h0;
      padHiPrev_reg <= 1'b0;
      padLoPrev_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      pending_reg <= pending_next;
      active_reg <= active_next;
      ien_reg <= ien_next;
      selLevel_reg <= selLevel_next;
      keyArmed_reg <= keyArmed_next;
      ctrl_reg <= ctrl_next;
      keyPrev_reg <= keyLines;
      padHiPrev_reg <= extPadHigh;
      padLoPrev_reg <= extPadLow;
    end
  end

  pic_vector_rom u_rom (
    .clk(clk),
    .nrst(nrst),
    .level(selLevel_next),
    .vector(romVector),
    .opcode(romOpcode)
  );

  assign irqRequest = higher && ien_reg;
  assign ackCycle = (state_reg == PIC_ACK);
  assign pushPc = (state_reg == PIC_ACK);
  assign vectorAddr = romVector;
  assign irqOpcode = romOpcode;
  assign irqEnableFlag = ien_reg;
  assign sleeping = (state_reg == PIC_SLEEP);
  assign oscRestart = (state_reg == PIC_SLEEP) && (|pending_reg);
  assign pendingBits = pending_reg;
  assign activeBits = active_reg;

  // Latency helper: instruction ends seen while a request waits
  logic [3:0] waitCnt;
  always_ff @(posedge clk)
  begin
    if (!nrst || !irqRequest || ackCycle)
      waitCnt <= 4'h0;
    else if (instrDone && waitCnt != 4'hF)
      waitCnt <= waitCnt + 4'h1;
  end

  AST_PEND_HELD: assert property (@(posedge clk) disable iff (!nrst)
    pending_reg[0] && !ien_reg && !returnFromIrqInstr |=> pending_reg[0])
    else $error("pending bit lost while disabled");
  AST_REQ_LATCH: assert property (@(posedge clk) disable iff (!nrst)
    softTrigger[0] |=> pending_reg[0])
    else $error("software trigger not latched");
  AST_RTI_CLEAR: assert property (@(posedge clk) disable iff (!nrst)
    state_reg == PIC_RUN && returnFromIrqInstr && active_reg == 8'h80
    && !softTrigger[7] && !hwReq[7] |=> !active_reg[7] && !pending_reg[7])
    else $error("return did not clear level");
  AST_NO_REQ_DISABLED: assert property (@(posedge clk) disable iff (!nrst)
    !ien_reg |-> !irqRequest)
    else $error("request while disabled");
  AST_ACK_AFTER_DONE: assert property (@(posedge clk) disable iff (!nrst)
    $rose(ackCycle) |-> $past(instrDone) && $past(ien_reg))
    else $error("acknowledge without instruction end");
  AST_ACK_ONE: assert property (@(posedge clk) disable iff (!nrst)
    ackCycle |=> !ackCycle && active_reg[$past(selLevel_reg)])
    else $error("acknowledge did not mark active");
  AST_VECTOR_TOP: assert property (@(posedge clk) disable iff (!nrst)
    ackCycle && selLevel_reg == `PIC_LVL_PADHI |-> vectorAddr == `PIC_VEC7
    && irqOpcode == `PIC_OPC7)
    else $error("wrong top vector");
  AST_WAKE: assert property (@(posedge clk) disable iff (!nrst)
    sleeping && (|pending_reg) |=> !sleeping)
    else $error("no wake on request");
  AST_RESET_CTRL: assert property (@(posedge clk)
    !nrst |=> ctrl_reg == 4'hF && pending_reg == 8'h00)
    else $error("reset state wrong");
  AST_LATENCY: assert property (@(posedge clk) disable iff (!nrst)
    waitCnt <= 4'(`PIC_LAT_MAX))
    else $error("latency exceeded");
  AST_KEY_DISARM: assert property (@(posedge clk) disable iff (!nrst)
    keyPortRead && !keyPortWrite |=> !keyArmed_reg)
    else $error("key port not disarmed");

  COV_ACK: cover property (@(posedge clk) disable iff (!nrst) ackCycle);
  COV_SLEEP: cover property (@(posedge clk) disable iff (!nrst) $rose(sleeping));
  COV_NEST: cover property (@(posedge clk) disable iff (!nrst) $countones(active_reg) == 2);
  COV_KEY: cover property (@(posedge clk) disable iff (!nrst) keyEdge);
endmodule
`default_nettype wire

//--- tb/pic_core_model.sv
/*
  Core sequencer model: ends instructions at a prompt or slow pace.
  Assumes the controller's sleeping output and one clock.
*/
`default_nettype none
module pic_core_model (
  input wire logic clk,
  input wire logic nrst,
  input wire logic slow,
  input wire logic sleeping,
  output logic instrDone
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] gapCnt;
  always @(posedge clk)
  begin
    if (!nrst)
    begin
      gapCnt <= 3'h0;
      instrDone <= 1'b0;
    end
    else
    begin
      // Instruction ends only while awake
      instrDone <= !sleeping && gapCnt == 3'h0 && !instrDone;
      gapCnt <= (gapCnt == 3'h0) ? (slow ? 3'h3 : 3'h0) : gapCnt - 3'h1;
    end
  end
endmodule
`default_nettype wire

//--- tb/testbench.sv
/*
  Self-checking bench of the interrupt controller.
  Assumes pic_core_model beside it and a 125 MHz clock.
*/
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, nrst, slow, instrDone, irqRequest, ackCycle, pushPc;
  logic irqEnableFlag, sleeping, oscRestart;
  logic [24:0] drv;
  logic keyPd, keyL4;
  logic [3:0] ctrlData;
  logic [7:0] pendingBits, activeBits, irqOpcode;
  logic [11:0] vectorAddr;
  int miscompares = 0;
  int samplesChecked = 0;
  int doneCount;
  logic [11:0] vecTab [8] = '{12'h040, 12'h080, 12'h0C0, 12'h100, 12'h140, 12'h180,
    12'h1C0, 12'h1E0};
  logic [7:0] opcTab [8] = '{8'hC8, 8'hD0, 8'hD8, 8'hE0, 8'hE8, 8'hF0, 8'hF8, 8'hFC};

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  pic_core_model core (.clk(clk), .nrst(nrst), .slow(slow), .sleeping(sleeping),
    .instrDone(instrDone));

  pic_controller uut (.clk(clk), .nrst(nrst), .instrDone(instrDone),
    .irqEnableInstr(drv[0]), .irqDisableInstr(drv[1]), .returnFromIrqInstr(drv[2]),
    .sleepInstr(drv[24]), .extPadHigh(drv[21]), .extPadLow(drv[20]),
    .prescalerFastIrq(drv[22]), .prescalerSlowIrq(drv[23]), .timer0Irq(drv[6]),
    .timer1Irq(drv[7]), .keyLines(drv[19:16]), .keyPullDown(keyPd), .keyAtLevel4(keyL4),
    .keyPortWrite(drv[3]), .keyPortRead(drv[4]), .softTrigger(drv[15:8]),
    .ctrlWrite(drv[5]), .ctrlData(ctrlData), .irqRequest(irqRequest),
    .ackCycle(ackCycle), .pushPc(pushPc), .vectorAddr(vectorAddr),
    .irqOpcode(irqOpcode), .irqEnableFlag(irqEnableFlag), .sleeping(sleeping),
    .oscRestart(oscRestart), .pendingBits(pendingBits), .activeBits(activeBits));

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    samplesChecked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wrap_up;
    if (miscompares == 0 && samplesChecked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Strobes idle low, pad and key lines idle high: two flips make a pulse or an edge pair
  task automatic toggle(input int b);
    @(posedge clk) drv[b] <= ~drv[b];
    @(posedge clk) drv[b] <= ~drv[b];
  endtask

  task automatic waitAck;
    int i;
    doneCount = 0;
    i = 0;
    do
    begin
      @(negedge clk);
      if (instrDone === 1'b1)
        doneCount++;
      i++;
    end
    while (ackCycle !== 1'b1 && i < 60);
    if (ackCycle !== 1'b1)
    begin
      miscompares++;
      wrap_up();
    end
  endtask

  task automatic noAck(input int c);
    int hits;
    hits = 0;
    repeat (c)
    begin
      @(negedge clk);
      if (ackCycle !== 1'b0)
        hits++;
    end
    check("noack", 16'(hits), 16'h0);
  endtask

  task automatic ret;
    toggle(2);
    @(negedge clk);
  endtask

  task automatic t_vectors;
    toggle(0);
    for (int n = 0; n < 8; n++)
    begin
      toggle(8 + n);
      waitAck();
      check("vector", 16'(vectorAddr), 16'(vecTab[n]));
      check("opcode", 16'(irqOpcode), 16'(opcTab[n]));
      check("push", 16'(pushPc), 16'h1);
      @(negedge clk);
      check("active", 16'(activeBits), 16'(8'h01 << n));
      ret();
      check("cleared", {pendingBits, activeBits}, 16'h0);
      check("asleep", 16'(sleeping), 16'h1);
    end
  endtask

  task automatic t_hold;
    toggle(1);
    toggle(20);
    repeat (3) @(negedge clk);
    toggle(20);
    noAck(20);
    check("held", 16'(pendingBits), 16'h0004);
    toggle(0);
    waitAck();
    check("vector", 16'(vectorAddr), 16'h00C0);
    ret();
    noAck(20);
    check("dropped", 16'(pendingBits), 16'h0);
  endtask

  task automatic t_prio;
    toggle(1);
    toggle(8);
    toggle(7);
    toggle(0);
    waitAck();
    check("vector", 16'(vectorAddr), 16'h0100);
    @(negedge clk);
    check("lowreq", 16'(irqRequest), 16'h0);
    toggle(21);
    waitAck();
    check("vector", 16'(vectorAddr), 16'h01E0);
    ret();
    noAck(10);
    ret();
    waitAck();
    check("vector", 16'(vectorAddr), 16'h0040);
    ret();
  endtask

  task automatic t_key;
    toggle(17);
    repeat (3) @(negedge clk);
    check("keyoff", 16'(pendingBits), 16'h0);
    toggle(3);
    toggle(16);
    waitAck();
    check("vector", 16'(vectorAddr), 16'h0080);
    ret();
    toggle(4);
    toggle(19);
    repeat (3) @(negedge clk);
    check("keyoff", 16'(pendingBits), 16'h0);
    @(posedge clk)
    begin
      keyPd <= 1'b1;
      keyL4 <= 1'b1;
    end
    toggle(3);
    toggle(16);
    waitAck();
    check("vector", 16'(vectorAddr), 16'h0140);
    ret();
    toggle(4);
    @(posedge clk)
    begin
      keyPd <= 1'b0;
      keyL4 <= 1'b0;
    end
  endtask

  task automatic t_src;
    toggle(22);
    waitAck();
    check("vector", 16'(vectorAddr), 16'h01C0);
    check("opcode", 16'(irqOpcode), 16'h00F8);
    ret();
    toggle(23);
    waitAck();
    check("vector", 16'(vectorAddr), 16'h0180);
    check("opcode", 16'(irqOpcode), 16'h00F0);
    ret();
  endtask

  task automatic t_ctrl;
    @(posedge clk) ctrlData <= 4'hB;
    toggle(5);
    toggle(20);
    repeat (3) @(negedge clk);
    check("masked", 16'(pendingBits), 16'h0);
    @(posedge clk) ctrlData <= 4'hE;
    toggle(5);
    toggle(20);
    waitAck();
    check("vector", 16'(vectorAddr), 16'h00C0);
    ret();
    @(posedge clk) ctrlData <= 4'hF;
    toggle(5);
  endtask

  task automatic t_wake;
    check("asleep", 16'(sleeping), 16'h1);
    toggle(21);
    @(negedge clk);
    check("oscrestart", 16'(oscRestart), 16'h1);
    @(negedge clk);
    check("awake", 16'(sleeping), 16'h0);
    waitAck();
    check("vector", 16'(vectorAddr), 16'h01E0);
    ret();
  endtask

  task automatic t_latency;
    @(posedge clk) slow <= 1'b1;
    toggle(6);
    waitAck();
    check("vector", 16'(vectorAddr), 16'h0140);
    check("latency", 16'(doneCount <= 5), 16'h1);
    ret();
    @(posedge clk) slow <= 1'b0;
  endtask

  task automatic t_rerun;
    toggle(1);
    toggle(13);
    @(negedge clk);
    check("pend", 16'(pendingBits), 16'h0020);
    @(posedge clk) nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    @(negedge clk);
    check("rst", {pendingBits, activeBits}, 16'h0);
    check("rsten", 16'(irqEnableFlag), 16'h0);
    toggle(24);
    @(negedge clk);
    check("sleepinstr", 16'(sleeping), 16'h1);
    check("sleepien", 16'(irqEnableFlag), 16'h1);
  endtask

  initial
  begin
    nrst = 1'b0;
    slow = 1'b0;
    drv = 25'h03F0000;
    keyPd = 1'b0;
    keyL4 = 1'b0;
    ctrlData = 4'hF;
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    @(negedge clk);
    check("rst", {pendingBits, activeBits}, 16'h0);
    check("rsten", 16'(irqEnableFlag), 16'h0);
    t_vectors();
    t_hold();
    t_prio();
    t_key();
    t_ctrl();
    t_wake();
    t_latency();
    t_src();
    t_rerun();
    wrap_up();
  end
endmodule
`default_nettype wire
